// file: hdl/spsd_pkg.sv
// Summary of operation
// - page stack view sits at 0xD3, decoded on page F only, resets to zero
// - view returns one stack byte; writes to it never change the stack
// - stack level index field in paging control picks the level shown
// - addresses with low nibble 0x0 or 0x8 are flagged bit-addressable
// - registers decode on pages 0 and F unless assigned to one page
// - undefined addresses are reserved; software must not rely on them
// - index 000 is the active page (top), 100 the bottom, above invalid
// - auto paging pushes page on interrupt entry, pops and restores on exit
// - active page at 0xA7 on every page, written by software, steers decode
package spsd_pkg;

  localparam logic [7:0] SPSD_ADDR_ACTIVE_PAGE = 8'ha7;
  localparam logic [7:0] SPSD_ADDR_PAGING_CTRL = 8'hcf;
  localparam logic [7:0] SPSD_ADDR_STACK_VIEW  = 8'hd3;

  localparam logic [7:0] SPSD_PAGE_0 = 8'h00;
  localparam logic [7:0] SPSD_PAGE_F = 8'h0f;

  localparam logic [7:0] SPSD_RST_ACTIVE_PAGE = 8'h00;
  localparam logic [7:0] SPSD_RST_PAGING_CTRL = 8'h01;
  localparam logic [7:0] SPSD_RST_STACK_VIEW  = 8'h00;

  // paging control fields; bits 7 and 3:1 are reserved and kept at zero
  localparam int         SPSD_IDX_LSB     = 4;
  localparam int         SPSD_EN_BIT      = 0;
  localparam logic [7:0] SPSD_CTRL_WMASK  = 8'h71;

  localparam int         SPSD_STACK_DEPTH = 5;
  localparam logic [2:0] SPSD_IDX_BOTTOM  = 3'h4;

  localparam logic [3:0] SPSD_BIT_NIB_A = 4'h0;
  localparam logic [3:0] SPSD_BIT_NIB_B = 4'h8;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } spsd_req_t;

  typedef struct packed {
    logic       valid;
    logic       own_hit;
    logic       bank_f;
    logic       bit_addr;
    logic       reserved;
    logic [7:0] rdata;
  } spsd_ans_t;

  // addresses whose register differs between page 0 and page F
  function automatic logic spsd_is_split(input logic [7:0] a);
    unique case (a)
      8'h91, 8'h92, 8'h93, 8'h94, 8'h95, 8'h96, 8'h97,
      8'hab, 8'hac, 8'had, 8'hae, 8'hb9,
      8'hc0, 8'hc1, 8'hc2, 8'hc8, 8'hca, 8'hcb, 8'hcc, 8'hcd,
      8'hd2, 8'hd3, 8'hd7, 8'he7:                      spsd_is_split = 1'b1;
      default:                                         spsd_is_split = 1'b0;
    endcase
  endfunction

  // undefined locations; some exist only on one page
  function automatic logic spsd_is_undef(input logic [7:0] a, input logic on_f);
    unique case (a)
      8'hb0, 8'hb4, 8'he5, 8'hf5: spsd_is_undef = 1'b1;
      8'had, 8'hae:               spsd_is_undef = !on_f;
      default:                    spsd_is_undef = (a < 8'h80);
    endcase
  endfunction

endpackage

// file: hdl/spsd_decode.sv
`timescale 1ns/10ps
module spsd_decode
  import spsd_pkg::*;
#(
  parameter int DEPTH = SPSD_STACK_DEPTH
)
(
  input  wire logic       clock,         // core clock
  input  wire logic       rst,           // synchronous reset, active high
  input  wire spsd_req_t  req,           // core register access, same clock
  input  wire logic       isr_enter,     // pulse: interrupt service entered
  input  wire logic [7:0] isr_page,      // page of the interrupting source
  input  wire logic       isr_exit,      // pulse: interrupt service left
  output spsd_ans_t       ans,           // decode result, one cycle after req
  output logic [7:0]      active_page,   // page currently steering decode
  output logic [7:0]      paging_control // control register contents
);

  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] stack_reg [DEPTH];
  logic [7:0] stack_next [DEPTH];
  logic [7:0] ctrl_reg;
  logic [7:0] ctrl_next;
  spsd_ans_t  ans_reg;
  spsd_ans_t  ans_next;
  logic       auto_paging_enable;
  logic [2:0] stack_level_index;
  logic       page_f;
  logic       page_ok;
  logic [7:0] page_stack_view;

  assign auto_paging_enable = ctrl_reg[SPSD_EN_BIT];
  assign stack_level_index  = ctrl_reg[SPSD_IDX_LSB +: 3];
  assign page_f             = (stack_reg[0] == SPSD_PAGE_F);
  assign page_ok            = page_f || (stack_reg[0] == SPSD_PAGE_0);

  // top of stack is the active page itself
  always_comb
  begin
    page_stack_view = SPSD_RST_STACK_VIEW;
    if (stack_level_index <= SPSD_IDX_BOTTOM)
      page_stack_view = stack_reg[stack_level_index];
  end

  ////////////////////////////////////////////////////////////////////////////
  // page stack and control
  always_comb
  begin
    stack_next = stack_reg;
    ctrl_next  = ctrl_reg;
    if (req.wr && req.addr == SPSD_ADDR_PAGING_CTRL)
      ctrl_next = req.wdata & SPSD_CTRL_WMASK;
    // hardware paging outranks a software page write in the same cycle
    if (auto_paging_enable && isr_enter)
    begin
      for (int i = DEPTH - 1; i > 0; i--)
        stack_next[i] = stack_reg[i - 1];
      stack_next[0] = isr_page;
    end
    else if (auto_paging_enable && isr_exit)
    begin
      for (int i = 0; i < DEPTH - 1; i++)
        stack_next[i] = stack_reg[i + 1];
      stack_next[DEPTH - 1] = SPSD_RST_ACTIVE_PAGE;
    end
    else if (req.wr && req.addr == SPSD_ADDR_ACTIVE_PAGE)
      stack_next[0] = req.wdata;
    // writes to the view address fall through untouched
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      for (int i = 0; i < DEPTH; i++)
        stack_reg[i] <= SPSD_RST_ACTIVE_PAGE;
      ctrl_reg <= SPSD_RST_PAGING_CTRL;
    end
    else
    begin
      stack_reg <= stack_next;
      ctrl_reg  <= ctrl_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // address decode, registered so every output comes from a flip-flop
  always_comb
  begin
    ans_next          = '0;
    ans_next.valid    = req.rd || req.wr;
    ans_next.bit_addr = (req.addr[3:0] == SPSD_BIT_NIB_A) ||
                        (req.addr[3:0] == SPSD_BIT_NIB_B);
    ans_next.bank_f   = page_f && spsd_is_split(req.addr);
    // pages other than 0 and F hold nothing but the shared registers
    ans_next.reserved = spsd_is_undef(req.addr, page_f) ||
                        (!page_ok && spsd_is_split(req.addr));
    unique case (req.addr)
      SPSD_ADDR_ACTIVE_PAGE:
      begin
        ans_next.own_hit = 1'b1;
        ans_next.rdata   = stack_reg[0];
      end
      SPSD_ADDR_PAGING_CTRL:
      begin
        ans_next.own_hit = 1'b1;
        ans_next.rdata   = ctrl_reg;
      end
      SPSD_ADDR_STACK_VIEW:
      begin
        ans_next.own_hit = page_f;
        ans_next.rdata   = page_f ? page_stack_view : SPSD_RST_STACK_VIEW;
      end
      default:
      begin
        ans_next.own_hit = 1'b0;
        ans_next.rdata   = 8'h00;
      end
    endcase
    if (!req.rd)
      ans_next.rdata = 8'h00;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      ans_reg <= '0;
    else
      ans_reg <= ans_next;
  end

  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] page_out_reg;
  logic [7:0] ctrl_out_reg;

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      page_out_reg <= SPSD_RST_ACTIVE_PAGE;
      ctrl_out_reg <= SPSD_RST_PAGING_CTRL;
    end
    else
    begin
      page_out_reg <= stack_next[0];
      ctrl_out_reg <= ctrl_next;
    end
  end

  assign ans            = ans_reg;
  assign active_page    = page_out_reg;
  assign paging_control = ctrl_out_reg;

endmodule

// file: bench/spsd_props.sv
`timescale 1ns/10ps
module spsd_props
  import spsd_pkg::*;
(
  input wire logic       clock,         // clk
  input wire logic       rst,           // reset
  input wire spsd_req_t  req,           // access
  input wire logic       isr_enter,     // entry
  input wire logic [7:0] isr_page,      // new page
  input wire logic       isr_exit,      // exit
  input wire spsd_ans_t  ans,           // answer
  input wire logic [7:0] active_page,   // page
  input wire logic [7:0] paging_control // control
);
  logic q;
  logic v;
  assign q = !isr_enter && !isr_exit;
  assign v = req.addr == 8'hd3;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  view_page_a: assert property (req.rd && v && active_page == 8'h00 |=> !ans.own_hit)
    else $error("view hit on page 0");
  view_ro_a: assert property (req.wr && v && q |=>
    $stable({paging_control, active_page}))
    else $error("view write took effect");
  bit_addr_a: assert property (req.rd |=> ans.bit_addr == ($past(req.addr[2:0]) == 3'h0))
    else $error("bit flag wrong");
  low_undef_a: assert property (req.rd && !req.addr[7] |=> ans.reserved && !ans.rdata)
    else $error("low address not reserved");
  page_wr_a: assert property (req.wr && req.addr == 8'ha7 && q |=>
    active_page == $past(req.wdata))
    else $error("page write lost");
  page_hold_a: assert property (!req.wr && q |=> $stable(active_page))
    else $error("page moved");
  isr_page_a: assert property (isr_enter && paging_control[0] |=>
    active_page == $past(isr_page))
    else $error("entry page not taken");
  bad_idx_a: assert property (req.rd && v && active_page == 8'h0f &&
    paging_control[6:4] > 3'h4 |=> ans.rdata == 8'h00)
    else $error("invalid index read nonzero");
endmodule

// file: bench/spsd_core_model.sv
`timescale 1ns/10ps
module spsd_core_model
  import spsd_pkg::*;
(
  input  wire logic  clock,     // clk
  output spsd_req_t  req,       // access
  output logic       isr_enter, // entry
  output logic       isr_exit,  // exit
  output logic [7:0] isr_page   // new page
);
  initial
  begin
    req = '0;
    isr_enter = 1'b0;
    isr_exit = 1'b0;
    isr_page = 8'h00;
  end
  ////////////////////////////////////////
  // idle lines carry the inverse so a stale value never looks valid
  task automatic acc(input logic r, input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    req <= '{r, w, a, d};
    @(posedge clock);
    req <= '{1'b0, 1'b0, ~a, ~d};
  endtask
  task automatic irq(input logic en, input logic [7:0] p);
    @(posedge clock);
    isr_enter <= en;
    isr_exit <= !en;
    isr_page <= p;
    @(posedge clock);
    isr_enter <= 1'b0;
    isr_exit <= 1'b0;
    isr_page <= ~p;
  endtask
endmodule

// file: bench/tb_top.sv
`timescale 1ns/10ps
module tb_top
  import spsd_pkg::*;
;
  logic        clock;
  logic        rst;
  spsd_req_t   req;
  logic        isr_enter;
  logic        isr_exit;
  logic [7:0]  isr_page;
  spsd_ans_t   ans;
  logic [7:0]  active_page;
  logic [7:0]  paging_control;
  logic [39:0] stk;
  logic [7:0]  ctrl;
  logic [31:0] r;
  int          failures;
  int          cmp_count;
  spsd_core_model u_core (.clock, .req, .isr_enter, .isr_exit, .isr_page);
  spsd_decode dut (.clock, .rst, .req, .isr_enter, .isr_page, .isr_exit, .ans, .active_page,
    .paging_control);
  ////////////////////////////////////////
  task automatic end_sim();
    if (failures == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    cmp_count++;
    if (s !== e)
    begin
      failures++;
      $display("MISMATCH %s exp %h got %h", n, e, s);
    end
  endtask
  function automatic logic [7:0] exp_rd(input logic [7:0] a);
    if (a == 8'ha7)
      return stk[7:0];
    if (a == 8'hcf)
      return ctrl;
    if (a != 8'hd3 || stk[7:0] != 8'h0f || ctrl[6:4] > 3'h4)
      return 8'h00;
    return stk[8 * ctrl[6:4] +: 8];
  endfunction
  // addresses that hold one register on page 0 and another on page F
  function automatic logic split_at(input logic [7:0] a);
    case (a)
      8'h91, 8'h92, 8'h93, 8'h94, 8'h95, 8'h96, 8'h97, 8'hab, 8'hac, 8'had, 8'hae, 8'hb9,
      8'hc0, 8'hc1, 8'hc2, 8'hc8, 8'hca, 8'hcb, 8'hcc, 8'hcd, 8'hd2, 8'hd3, 8'hd7, 8'he7:
        return 1'b1;
      default:
        return 1'b0;
    endcase
  endfunction
  // {valid, own hit, page f variant, bit addressable, reserved} for the current page
  function automatic logic [7:0] exp_flags(input logic [7:0] a);
    logic f;
    logic u;
    f = stk[7:0] == 8'h0f;
    u = a < 8'h80 || a == 8'hb0 || a == 8'hb4 || a == 8'he5 || a == 8'hf5 ||
      (!f && (a == 8'had || a == 8'hae)) || (!f && stk[7:0] != 8'h00 && split_at(a));
    return {3'h0, 1'b1, (a == 8'ha7 || a == 8'hcf || (a == 8'hd3 && f)), (f && split_at(a)),
      (a[3:0] == 4'h0 || a[3:0] == 4'h8), u};
  endfunction
  task automatic rd(input logic [7:0] a);
    logic [7:0] e;
    e = exp_flags(a);
    u_core.acc(1'b1, 1'b0, a, 8'h00);
    #1;
    chk("rdata", exp_rd(a), ans.rdata);
    chk("resv", {7'h0, e[0]}, {7'h0, ans.reserved});
    chk("flags", e, {3'h0, ans.valid, ans.own_hit, ans.bank_f, ans.bit_addr, ans.reserved});
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] e;
    e = exp_flags(a);
    u_core.acc(1'b0, 1'b1, a, d);
    if (a == 8'ha7)
      stk[7:0] = d;
    if (a == 8'hcf)
      ctrl = d & SPSD_CTRL_WMASK;
    #1;
    chk("flags", e, {3'h0, ans.valid, ans.own_hit, ans.bank_f, ans.bit_addr, ans.reserved});
    chk("page", stk[7:0], active_page);
    chk("ctrl", ctrl, paging_control);
  endtask
  task automatic isr(input logic en, input logic [7:0] p);
    u_core.irq(en, p);
    if (ctrl[0])
      stk = en ? {stk[31:0], p} : {8'h00, stk[39:8]};
    #1;
    chk("page", stk[7:0], active_page);
  endtask
  ////////////////////////////////////////
  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  initial
  begin
    failures = 0;
    cmp_count = 0;
    stk = '0;
    ctrl = SPSD_RST_PAGING_CTRL;
    rst = 1'b1;
    r = $urandom(32'hf5fd545a);
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    rd(8'hd3);
    wr(8'hcf, 8'hc1);
    for (int i = 0; i < 5; i++)
      isr(1'b1, {4'h0, {4{!i[0]}}});
    for (int i = 0; i < 400; i++)
    begin
      r = $urandom;
      case (r[2:0])
        3'h0: wr(8'ha7, {4'h0, {4{r[8]}}});
        3'h1: wr(8'hcf, r[15:8]);
        3'h2: wr(8'hd3, r[15:8]);
        3'h3: isr(r[8], {4'h0, {4{r[9]}}});
        3'h4: rd({1'b0, r[14:8]});
        3'h5: rd(r[15:8]);
        default: rd(r[3] ? 8'hd3 : (r[4] ? 8'he0 : (r[5] ? 8'ha7 : 8'hcf)));
      endcase
    end
    // fill deeper levels, then reset mid-run: level 1 must read back as zero
    wr(8'hcf, 8'h11);
    isr(1'b1, 8'h0f);
    isr(1'b1, 8'h0f);
    @(posedge clock);
    rst <= 1'b1;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    stk = '0;
    ctrl = SPSD_RST_PAGING_CTRL;
    rd(8'hcf);
    rd(8'ha7);
    wr(8'ha7, 8'h0f);
    wr(8'hcf, 8'h11);
    rd(8'hd3);
    end_sim();
  end
endmodule
bind spsd_decode spsd_props u_props (.clock, .rst, .req, .isr_enter, .isr_page, .isr_exit,
  .ans, .active_page, .paging_control);
